// >>> rtl/scctl_defines.vh
// constants for the system control and interrupt capture block
// assumes a 20 MHz system clock and a classic wishbone register port
`ifndef SCCTL_DEFINES_VH
`define SCCTL_DEFINES_VH
`define SCC_CLK_HZ 20000000
`define SCC_TIMER_CLOCK_HZ 100000
`define SCC_TIMER_CLOCK_DIV (`SCC_CLK_HZ / `SCC_TIMER_CLOCK_HZ)
`define SCC_TB_RATIO 10
// register byte addresses
`define SCC_A_CTRL 8'h00
`define SCC_A_STAT 8'h04
`define SCC_A_CMD 8'h08
`define SCC_A_PIRQ 8'h0c
`define SCC_A_FAULT 8'h10
`define SCC_A_TMRA 8'h14
`define SCC_A_TMRB 8'h18
`define SCC_A_TGO 8'h1c
`define SCC_A_CONF 8'h20
// command bits (write 1 to act)
`define SCC_C_DMA_ENABLE_OUT_ON 0
`define SCC_C_DMA_ENABLE_OUT_OFF 1
`define SCC_C_ROM_ON 2
`define SCC_C_ROM_OFF 3
`define SCC_C_NPU_CLR 4
`define SCC_C_GO 5
`define SCC_C_BPT 6
`define SCC_C_INSTR_END 7
`define SCC_C_BIT_PASS 8
`define SCC_C_TMR_CLR 9
// fault, config and pending interrupt bits
`define SCC_CONF_CONSOLE 15
`define SCC_F_MPROT_MEM 0
`define SCC_F_MPROT_DMA 1
`define SCC_F_MPAR 2
`define SCC_F_PIOPAR 3
`define SCC_F_DMAPAR 4
`define SCC_PI_PWR 0
`define SCC_PI_MACH 1
`define SCC_PI_IO1 12
`define SCC_PI_IO2 14
`define SCC_PI_U0 2
`define SCC_PI_U1 8
`define SCC_PI_U2 10
`define SCC_PI_U3 11
`define SCC_PI_U4 13
`define SCC_PI_U5 15
`define SCC_CYC_LEN 5
`endif

// >>> rtl/scctl_sync.v
// one machine cycle generator: cycle_sync_n falls at the start of each cycle
// assumes a single clock; the fall is reported as a one-cycle pulse
`timescale 1ns/1ps
module scctl_sync #(
	parameter LEN = 5
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// outputs
	output reg cycle_sync_n_o,
	output wire sync_fall_o
);
	reg [3:0] cnt_q;
	// pulse in the cycle whose edge drops cycle_sync_n
	assign sync_fall_o = (cnt_q == LEN[3:0] - 4'h1);
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 4'h0;
			cycle_sync_n_o <= 1'b1;
		end else begin
			cnt_q <= sync_fall_o ? 4'h0 : cnt_q + 4'h1;
			cycle_sync_n_o <= ~sync_fall_o;
		end
	end
endmodule

// >>> rtl/scctl_div.v
// rate enable divider producing one-cycle pulses
// assumes a single clock and a synchronous enable input
`timescale 1ns/1ps
module scctl_div #(
	parameter DIV = 10,
	parameter W = 8
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// enable in and pulse out
	input wire en_i,
	output wire tick_o
);
	reg [W-1:0] cnt_q;
	assign tick_o = en_i & (cnt_q == DIV[W-1:0] - {{(W-1){1'b0}}, 1'b1});
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= {W{1'b0}};
		end else if (en_i) begin
			cnt_q <= tick_o ? {W{1'b0}} : cnt_q + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// >>> rtl/scctl_top.v
// system control, timers and interrupt capture of a 16-bit processor
// assumes inputs synchronous to clk_i; registers over classic wishbone
`timescale 1ns/1ps
`include "scctl_defines.vh"
module scctl_top #(
	parameter TIMER_CLOCK_DIV = `SCC_TIMER_CLOCK_DIV,
	parameter TB_RATIO = `SCC_TB_RATIO,
	parameter TO_LIMIT = 2
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output wire ack_o,
	// dma and hold
	input wire dma_request_n_i,
	input wire hold_request_n_i,
	output reg dma_grant_n_o,
	output reg dma_enable_out_o,
	output reg hold_grant_n_o,
	// bus driver control
	output wire bus_drive_oe_o,
	output wire control_direction_n_o,
	output wire data_direction_n_o,
	output wire cycle_sync_n_o,
	output wire instr_abort_o,
	// configuration register
	input wire [15:0] config_word_i,
	output reg config_read_strobe_n_o,
	// discretes
	output reg startup_rom_enable_o,
	output reg normal_powerup_o,
	output reg trigger_go_out_n_o,
	output reg bus_timeout_o,
	// timer inputs
	input wire trigger_go_clock_i,
	input wire timer_disable_n_i,
	input wire timeout_disable_n_i,
	input wire bus_ready_n_i,
	input wire dma_cycle_i,
	// interrupt and fault inputs
	input wire power_down_irq_n_i,
	input wire [5:0] user_irq_n_i,
	input wire io_irq_one_n_i,
	input wire io_irq_two_n_i,
	input wire mem_protect_err_n_i,
	input wire mem_parity_err_n_i,
	input wire pio_parity_err_n_i,
	input wire dma_parity_err_n_i
);
	localparam ST_RUN = 4'b0001;
	localparam ST_DMA = 4'b0010;
	localparam ST_HOLD = 4'b0100;
	localparam ST_BPTH = 4'b1000;
	localparam IN_CONF = 3'b001;
	localparam IN_BIT = 3'b010;
	localparam IN_DONE = 3'b100;

	reg [3:0] st_q;
	reg [2:0] init_q;
	reg ack_q;
	reg [15:0] conf_q;
	reg [15:0] pirq_q;
	reg [15:0] fault_q;
	reg [15:0] tmra_q;
	reg [15:0] tmrb_q;
	reg [15:0] tgo_q;
	reg hold_pend_q;
	reg bpt_low_q;
	reg trigger_go_clock_q;
	reg [1:0] to_q;
	reg [15:0] irq_set;
	wire sync_fall;
	wire tick_a;
	wire tick_b;
	wire run_tmr;
	wire wr;
	wire [15:0] cmd;
	wire mprot;
	wire bpt_console;

	// one word per register; ack answers one cycle after the strobe
	assign wr = cyc_i & stb_i & we_i & ~ack_q & sel_i[0];
	assign ack_o = ack_q;
	assign cmd = (wr && adr_i == `SCC_A_CMD) ? dat_i[15:0] : 16'h0000;
	assign run_tmr = timer_disable_n_i;
	assign mprot = ~mem_protect_err_n_i;
	// decided on the fresh word, never on the one latched at start-up
	assign bpt_console = ~config_read_strobe_n_o &
		~config_word_i[`SCC_CONF_CONSOLE];

	scctl_sync #(
		.LEN(`SCC_CYC_LEN)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cycle_sync_n_o(cycle_sync_n_o),
		.sync_fall_o(sync_fall)
	);

	// timer clock derived from the system clock
	scctl_div #(
		.DIV(TIMER_CLOCK_DIV),
		.W(8)
	) u_div_a (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(run_tmr),
		.tick_o(tick_a)
	);

	scctl_div #(
		.DIV(TB_RATIO),
		.W(4)
	) u_div_b (
		.clk_i(clk_i),
		.rst_i(rst_i | cmd[`SCC_C_TMR_CLR]),
		.en_i(tick_a),
		.tick_o(tick_b)
	);

	// bus drivers float whenever another party owns the bus
	assign bus_drive_oe_o = st_q == ST_RUN;
	assign control_direction_n_o = st_q == ST_RUN;
	// direction low while granted or reading the configuration word
	assign data_direction_n_o = (st_q == ST_RUN) &
		config_read_strobe_n_o;
	assign instr_abort_o = sync_fall & mprot & ~dma_cycle_i;

	// ownership state machine
	always @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= ST_RUN;
			dma_grant_n_o <= 1'b1;
			hold_grant_n_o <= 1'b1;
			hold_pend_q <= 1'b0;
			bpt_low_q <= 1'b0;
		end else begin
			// request seen now is served at the next instruction end
			if (~hold_request_n_i) begin
				hold_pend_q <= 1'b1;
			end
			case (st_q)
			ST_RUN: begin
				if (init_q == IN_DONE && sync_fall && dma_enable_out_o &&
					run_tmr && ~dma_request_n_i) begin
					st_q <= ST_DMA;
					dma_grant_n_o <= 1'b0;
				end else if (init_q == IN_DONE && cmd[`SCC_C_INSTR_END] &&
					(hold_pend_q | ~hold_request_n_i)) begin
					st_q <= ST_HOLD;
					hold_grant_n_o <= 1'b0;
				end else if (init_q == IN_DONE && bpt_console) begin
					st_q <= ST_BPTH;
					bpt_low_q <= 1'b0;
					hold_grant_n_o <= 1'b0;
				end
			end
			ST_DMA: begin
				if (dma_request_n_i || !run_tmr) begin
					st_q <= ST_RUN;
					dma_grant_n_o <= 1'b1;
				end
			end
			ST_HOLD: begin
				if (hold_request_n_i) begin
					st_q <= ST_RUN;
					hold_pend_q <= 1'b0;
					hold_grant_n_o <= 1'b1;
				end
			end
			ST_BPTH: begin
				// needs a fresh low then high on the request
				if (~hold_request_n_i) begin
					bpt_low_q <= 1'b1;
				end else if (bpt_low_q) begin
					st_q <= ST_RUN;
					hold_pend_q <= 1'b0;
					hold_grant_n_o <= 1'b1;
				end
			end
			default: begin
				st_q <= ST_RUN;
			end
			endcase
		end
	end

	// initialisation: config read, self-test, then run
	always @(posedge clk_i) begin
		if (rst_i) begin
			init_q <= IN_CONF;
			config_read_strobe_n_o <= 1'b1;
			conf_q <= 16'hffff;
			startup_rom_enable_o <= 1'b0;
			normal_powerup_o <= 1'b0;
			dma_enable_out_o <= 1'b0;
		end else begin
			config_read_strobe_n_o <= 1'b1;
			case (init_q)
			IN_CONF: begin
				if (config_read_strobe_n_o) begin
					config_read_strobe_n_o <= 1'b0;
				end else begin
					// low bits are not used by the block
					conf_q <= {config_word_i[15:12], 12'h000};
					init_q <= IN_BIT;
				end
			end
			IN_BIT: begin
				normal_powerup_o <= 1'b0;
				startup_rom_enable_o <= 1'b1;
				init_q <= IN_DONE;
			end
			IN_DONE: begin
				if (cmd[`SCC_C_BPT]) begin
					config_read_strobe_n_o <= 1'b0;
				end
				if (!config_read_strobe_n_o) begin
					conf_q <= {config_word_i[15:12], 12'h000};
				end
			end
			default: begin
				init_q <= IN_CONF;
			end
			endcase
			// only the self-test pass may raise it
			if (cmd[`SCC_C_NPU_CLR]) begin
				normal_powerup_o <= 1'b0;
			end else if (cmd[`SCC_C_BIT_PASS] && init_q == IN_DONE) begin
				normal_powerup_o <= 1'b1;
			end
			if (cmd[`SCC_C_ROM_OFF]) begin
				startup_rom_enable_o <= 1'b0;
			end else if (cmd[`SCC_C_ROM_ON]) begin
				startup_rom_enable_o <= 1'b1;
			end
			if (!run_tmr || cmd[`SCC_C_DMA_ENABLE_OUT_OFF]) begin
				dma_enable_out_o <= 1'b0;
			end else if (cmd[`SCC_C_DMA_ENABLE_OUT_ON]) begin
				dma_enable_out_o <= 1'b1;
			end
		end
	end

	// timers; trigger-go clock edges counted on the rising edge
	always @(posedge clk_i) begin
		if (rst_i) begin
			tmra_q <= 16'h0000;
			tmrb_q <= 16'h0000;
			tgo_q <= 16'h0000;
			trigger_go_clock_q <= 1'b0;
			trigger_go_out_n_o <= 1'b1;
		end else begin
			trigger_go_clock_q <= trigger_go_clock_i;
			if (cmd[`SCC_C_TMR_CLR]) begin
				tmra_q <= 16'h0000;
				tmrb_q <= 16'h0000;
			end else begin
				if (tick_a) begin
					tmra_q <= tmra_q + 16'h0001;
				end
				if (tick_b) begin
					tmrb_q <= tmrb_q + 16'h0001;
				end
			end
			if (cmd[`SCC_C_GO]) begin
				tgo_q <= 16'h0000;
				trigger_go_out_n_o <= 1'b1;
			end else if (run_tmr && trigger_go_clock_i && !trigger_go_clock_q) begin
				tgo_q <= tgo_q + 16'h0001;
				if (tgo_q == 16'hffff) begin
					trigger_go_out_n_o <= 1'b0;
				end
			end
		end
	end

	// bus fault timer: ready held high over two timer ticks
	always @(posedge clk_i) begin
		if (rst_i || !timeout_disable_n_i) begin
			to_q <= 2'b00;
			bus_timeout_o <= 1'b0;
		end else if (bus_ready_n_i) begin
			if (tick_a && to_q != TO_LIMIT[1:0]) begin
				to_q <= to_q + 2'b01;
			end
			bus_timeout_o <= to_q == TO_LIMIT[1:0];
		end else begin
			to_q <= 2'b00;
			bus_timeout_o <= 1'b0;
		end
	end

	// capture set terms, sampled at the cycle sync fall
	always @* begin
		irq_set = 16'h0000;
		if (sync_fall) begin
			irq_set[`SCC_PI_PWR] = ~power_down_irq_n_i;
			irq_set[`SCC_PI_U0] = ~user_irq_n_i[0];
			irq_set[`SCC_PI_U1] = ~user_irq_n_i[1];
			irq_set[`SCC_PI_U2] = ~user_irq_n_i[2];
			irq_set[`SCC_PI_U3] = ~user_irq_n_i[3];
			irq_set[`SCC_PI_U4] = ~user_irq_n_i[4];
			irq_set[`SCC_PI_U5] = ~user_irq_n_i[5];
			irq_set[`SCC_PI_IO1] = ~io_irq_one_n_i;
			irq_set[`SCC_PI_IO2] = ~io_irq_two_n_i;
			irq_set[`SCC_PI_MACH] = mprot | ~mem_parity_err_n_i |
				~pio_parity_err_n_i | ~dma_parity_err_n_i;
		end
	end

	// sticky registers; set beats a same-cycle clear
	always @(posedge clk_i) begin
		if (rst_i) begin
			pirq_q <= 16'h0000;
			fault_q <= 16'h0000;
			ack_q <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_q <= cyc_i & stb_i & ~ack_q;
			if (wr && adr_i == `SCC_A_PIRQ) begin
				pirq_q <= (pirq_q & ~dat_i[15:0]) | irq_set;
			end else begin
				pirq_q <= pirq_q | irq_set;
			end
			if (wr && adr_i == `SCC_A_FAULT) begin
				fault_q <= fault_q & ~dat_i[15:0];
			end
			if (sync_fall) begin
				if (mprot && !dma_cycle_i) begin
					fault_q[`SCC_F_MPROT_MEM] <= 1'b1;
				end
				if (mprot && dma_cycle_i) begin
					fault_q[`SCC_F_MPROT_DMA] <= 1'b1;
				end
				if (!mem_parity_err_n_i) begin
					fault_q[`SCC_F_MPAR] <= 1'b1;
				end
				if (!pio_parity_err_n_i) begin
					fault_q[`SCC_F_PIOPAR] <= 1'b1;
				end
				if (!dma_parity_err_n_i) begin
					fault_q[`SCC_F_DMAPAR] <= 1'b1;
				end
			end
			dat_o <= 32'h00000000;
			if (adr_i == `SCC_A_CTRL) begin
				dat_o[2:0] <= {normal_powerup_o, startup_rom_enable_o,
					dma_enable_out_o};
			end else if (adr_i == `SCC_A_STAT) begin
				dat_o[10:0] <= {trigger_go_out_n_o, bus_timeout_o,
					hold_grant_n_o, dma_grant_n_o, init_q, st_q};
			end else if (adr_i == `SCC_A_PIRQ) begin
				dat_o[15:0] <= pirq_q;
			end else if (adr_i == `SCC_A_FAULT) begin
				dat_o[15:0] <= fault_q;
			end else if (adr_i == `SCC_A_TMRA) begin
				dat_o[15:0] <= tmra_q;
			end else if (adr_i == `SCC_A_TMRB) begin
				dat_o[15:0] <= tmrb_q;
			end else if (adr_i == `SCC_A_TGO) begin
				dat_o[15:0] <= tgo_q;
			end else if (adr_i == `SCC_A_CONF) begin
				dat_o[15:0] <= conf_q;
			end
		end
	end
endmodule

// >>> testbench/scctl_top_assertions.sv
// checker for the system control block, bound to its top module
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ps
module scctl_top_chk (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// requests and causes
	input wire dma_request_n_i,
	input wire timer_disable_n_i,
	input wire mem_protect_err_n_i,
	input wire dma_cycle_i,
	// grants and bus control
	input wire dma_grant_n_o,
	input wire dma_enable_out_o,
	input wire hold_grant_n_o,
	input wire bus_drive_oe_o,
	input wire control_direction_n_o,
	input wire data_direction_n_o,
	input wire cycle_sync_n_o,
	input wire instr_abort_o,
	input wire config_read_strobe_n_o,
	input wire startup_rom_enable_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_period;
		cycle_sync_n_o [*4] ##1 !cycle_sync_n_o;
	endsequence
	// the rom enable may only follow the configuration read
	sequence s_init;
		##[0:2] !config_read_strobe_n_o ##[1:3] startup_rom_enable_o;
	endsequence
	sync_period_a: assert property (
		$fell(cycle_sync_n_o) |=> s_period) else $error("bad cycle length");
	init_order_a: assert property (
		$fell(rst_i) |-> s_init) else $error("bad init sequence");
	grant_at_sync_a: assert property (
		$fell(dma_grant_n_o) |-> $fell(cycle_sync_n_o))
		else $error("grant off sync");
	grant_cause_a: assert property (
		$fell(dma_grant_n_o) |-> $past(!dma_request_n_i && dma_enable_out_o
		&& timer_disable_n_i)) else $error("grant without cause");
	grant_keep_a: assert property (
		!dma_grant_n_o && !dma_request_n_i && timer_disable_n_i
		|=> !dma_grant_n_o) else $error("grant dropped early");
	grant_drop_a: assert property (
		!dma_grant_n_o && dma_request_n_i |=> dma_grant_n_o)
		else $error("grant not released");
	dtimer_kill_a: assert property (
		!timer_disable_n_i |=> !dma_enable_out_o && dma_grant_n_o)
		else $error("dma alive while timers off");
	bus_float_a: assert property (
		!dma_grant_n_o || !hold_grant_n_o |-> !bus_drive_oe_o
		&& !control_direction_n_o && !data_direction_n_o)
		else $error("bus driven while granted");
	conf_dir_a: assert property (
		!config_read_strobe_n_o |-> !data_direction_n_o)
		else $error("direction high in config read");
	abort_cause_a: assert property (
		instr_abort_o |-> !mem_protect_err_n_i && !dma_cycle_i)
		else $error("abort without memory protect error");
	abort_fire_a: assert property (
		$fell(cycle_sync_n_o) && $past(!mem_protect_err_n_i && !dma_cycle_i)
		|-> $past(instr_abort_o)) else $error("memory protect not aborted");
endmodule
bind scctl_top scctl_top_chk u_chk (.*);

// >>> testbench/scctl_far_model.sv
// far side: dma requester and console hold requester
// assumes the bench raises the go lines just after a clock edge
`timescale 1ns/1ps
module scctl_far_model #(
	parameter SPAN = 6
) (
	// clock, reset and bench control
	input wire clk_i,
	input wire rst_i,
	input wire dma_go_i,
	input wire hold_go_i,
	input wire bpt_i,
	// grants in, requests out
	input wire dma_grant_n_i,
	input wire hold_grant_n_i,
	output logic dma_request_n_o,
	output logic hold_request_n_o
);
	int dn;
	int hn;
	// requests move only just after an edge, as a strobe-synced source
	always @(posedge clk_i) begin
		if (rst_i || !dma_go_i) begin
			dma_request_n_o <= 1'b1;
			dn <= 0;
		end else if (dn == 0) begin
			dma_request_n_o <= 1'b0;
			dn <= 1;
		end else if (!dma_grant_n_i) begin
			dn <= dn + 1;
			if (dn == SPAN) dma_request_n_o <= 1'b1;
		end
		if (rst_i || !hold_go_i) begin
			hold_request_n_o <= 1'b1;
			hn <= 0;
		end else if (hn == 0) begin
			hold_request_n_o <= bpt_i;
			hn <= 1;
		end else if (!hold_grant_n_i || hn > SPAN) begin
			hn <= hn + 1;
			if (hn == SPAN) hold_request_n_o <= !bpt_i;
			if (hn == SPAN + 1) hold_request_n_o <= 1'b1;
		end
	end
endmodule

// >>> testbench/tb_scctl_top.sv
// self-checking bench for the system control block
// assumes the far model and the bound checker; timer divider shortened
`timescale 1ns/1ps
module tb_scctl_top;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, tgc = 0;
	logic tdis_n = 1, tod_n = 1, rdy_n = 0, dcyc = 0, pwr_n = 1;
	logic io1_n = 1, io2_n = 1, mpro_n = 1, mpar_n = 1, piop_n = 1;
	logic dpar_n = 1, dgo = 0, hgo = 0, breakpoint_instr = 0;
	logic [5:0] uirq_n = 6'h3f;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, rd, ta;
	logic [15:0] conf = 16'hffff;
	wire [31:0] dat_o;
	wire ack_o, dg_n, de, hg_n, oe, cd_n, dd_n, rom, normal_powerup, tgo_n, bto;
	wire dreq_n, hreq_n;
	int num_errors = 0, n_checks = 0;
	int pib[14] = '{0, 2, 8, 10, 11, 13, 15, 12, 14, 1, 1, 1, 1, 1};
	always #25 clk_i = ~clk_i;
	scctl_top #(.TIMER_CLOCK_DIV(4)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wd), .dat_o(dat_o),
		.ack_o(ack_o), .dma_request_n_i(dreq_n), .hold_request_n_i(hreq_n),
		.dma_grant_n_o(dg_n), .dma_enable_out_o(de), .hold_grant_n_o(hg_n),
		.bus_drive_oe_o(oe), .control_direction_n_o(cd_n),
		.data_direction_n_o(dd_n), .cycle_sync_n_o(), .instr_abort_o(),
		.config_word_i(conf), .config_read_strobe_n_o(),
		.startup_rom_enable_o(rom), .normal_powerup_o(normal_powerup),
		.trigger_go_out_n_o(tgo_n), .bus_timeout_o(bto),
		.trigger_go_clock_i(tgc), .timer_disable_n_i(tdis_n),
		.timeout_disable_n_i(tod_n), .bus_ready_n_i(rdy_n),
		.dma_cycle_i(dcyc), .power_down_irq_n_i(pwr_n),
		.user_irq_n_i(uirq_n), .io_irq_one_n_i(io1_n),
		.io_irq_two_n_i(io2_n), .mem_protect_err_n_i(mpro_n),
		.mem_parity_err_n_i(mpar_n), .pio_parity_err_n_i(piop_n),
		.dma_parity_err_n_i(dpar_n));
	scctl_far_model u_far (.clk_i(clk_i), .rst_i(rst_i), .dma_go_i(dgo),
		.hold_go_i(hgo), .bpt_i(breakpoint_instr), .dma_grant_n_i(dg_n),
		.hold_grant_n_i(hg_n), .dma_request_n_o(dreq_n),
		.hold_request_n_o(hreq_n));
	task results;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task bad(input string m);
		num_errors++;
		$display("BAD %0t %s", $time, m);
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e) bad($sformatf("%s got %h exp %h", m, g, e));
	endtask
	// classic cycle: request held until ack is sampled high
	// no local limit: only the watchdog ends a wait for ack
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc <= 0; stb <= 0; we <= 0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
		wb(0, a, 0);
		chk(rd, e, m);
	endtask
	task clk_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task t_init;
		rdchk(8'h00, 32'h2, "ctrl after init");
		rdchk(8'h0c, 32'h0, "pi after init");
		rdchk(8'h40, 32'h0, "unmapped read");
		$display("init test done");
	endtask
	task t_cmd;
		wb(1, 8'h00, 32'h7); // read-only place ignores writes
		wb(1, 8'h08, 32'h8);
		rdchk(8'h00, 32'h0, "rom off");
		wb(1, 8'h08, 32'h4);
		chk(rom, 1, "rom on");
		wb(1, 8'h08, 32'h100);
		rdchk(8'h00, 32'h6, "self-test pass");
		wb(1, 8'h08, 32'h10);
		chk(normal_powerup, 0, "npu cleared");
		$display("command test done");
	endtask
	task set_in(input int i, input logic v);
		case (i)
			0: pwr_n <= v;
			1, 2, 3, 4, 5, 6: uirq_n[i-1] <= v;
			7: io1_n <= v;
			8: io2_n <= v;
			9: mpro_n <= v;
			10: begin
				mpro_n <= v;
				dcyc <= !v;
			end
			11: mpar_n <= v;
			12: piop_n <= v;
			default: dpar_n <= v;
		endcase
	endtask
	// each capture must outlive the input: read only after release
	task t_irq;
		logic [31:0] pim, ftm;
		for (int i = 0; i < 14; i++) begin
			pim = 32'h1 << pib[i];
			ftm = (i > 8) ? 32'h1 << (i - 9) : 32'h0;
			set_in(i, 0);
			clk_n(7);
			set_in(i, 1);
			clk_n(3);
			rdchk(8'h0c, pim, "pending");
			rdchk(8'h10, ftm, "fault");
			wb(1, 8'h10, ftm);
			wb(1, 8'h0c, pim);
			rdchk(8'h0c, 32'h0, "pending cleared");
		end
		$display("interrupt test done");
	endtask
	task t_dma;
		dgo <= 1;
		clk_n(20);
		chk(dg_n, 1, "grant with enable low");
		dgo <= 0;
		wb(1, 8'h08, 32'h1);
		chk(de, 1, "dma enable");
		dgo <= 1;
		repeat (40) if (dg_n !== 1'b0) @(posedge clk_i);
		chk({oe, cd_n, dd_n, dg_n}, 0, "dma granted");
		repeat (40) if (dg_n !== 1'b1) @(posedge clk_i);
		chk(dg_n, 1, "dma released");
		dgo <= 0;
		tdis_n <= 0;
		clk_n(2);
		dgo <= 1;
		clk_n(20);
		chk({de, dg_n}, 1, "dma killed");
		dgo <= 0;
		tdis_n <= 1;
		wb(1, 8'h08, 32'h1);
		chk(de, 1, "dma enable after release");
		wb(1, 8'h08, 32'h2);
		chk(de, 0, "dma enable off");
		$display("dma test done");
	endtask
	task t_hold;
		hgo <= 1;
		clk_n(10);
		chk(hg_n, 1, "hold before instr end");
		wb(1, 8'h08, 32'h80);
		repeat (20) if (hg_n !== 1'b0) @(posedge clk_i);
		chk({oe, hg_n}, 0, "hold granted");
		repeat (40) if (hg_n !== 1'b1) @(posedge clk_i);
		chk(hg_n, 1, "hold released");
		hgo <= 0;
		clk_n(1);
		conf <= 16'h7fff;
		breakpoint_instr <= 1;
		hgo <= 1;
		wb(1, 8'h08, 32'h40);
		repeat (20) if (hg_n !== 1'b0) @(posedge clk_i);
		chk(hg_n, 0, "breakpoint hold");
		repeat (40) if (hg_n !== 1'b1) @(posedge clk_i);
		chk(hg_n, 1, "breakpoint release");
		hgo <= 0;
		breakpoint_instr <= 0;
		conf <= 16'h8000;
		wb(1, 8'h08, 32'h40);
		clk_n(20);
		chk(hg_n, 1, "breakpoint as no-op");
		$display("hold test done");
	endtask
	task t_timer;
		wb(1, 8'h08, 32'h220);
		clk_n(400);
		tdis_n <= 0;
		repeat (3) @(posedge clk_i) tgc <= !tgc;
		wb(0, 8'h14, 0);
		ta = rd;
		chk(ta == 0, 0, "timer a counted");
		rdchk(8'h18, ta / 10, "timer b ratio");
		clk_n(40);
		rdchk(8'h14, ta, "timer a frozen");
		rdchk(8'h1c, 32'h0, "go counter frozen");
		tdis_n <= 1;
		repeat (10) @(posedge clk_i) tgc <= !tgc;
		rdchk(8'h1c, 32'h5, "go counter");
		chk(tgo_n, 1, "go output");
		$display("timer test done");
	endtask
	task t_tmo;
		tod_n <= 0;
		rdy_n <= 1;
		clk_n(30);
		chk(bto, 0, "timeout disabled");
		tod_n <= 1;
		clk_n(30);
		chk(bto, 1, "timeout");
		rdy_n <= 0;
		$display("timeout test done");
	endtask
	initial begin
		clk_n(12);
		rst_i <= 0;
		clk_n(10);
		t_init;
		t_cmd;
		t_irq;
		t_dma;
		t_hold;
		t_timer;
		t_tmo;
		results;
	end
	initial begin
		clk_n(20000);
		num_errors++;
		results;
	end
endmodule
